/* File: src/pir_pkg.sv */
// Purpose: Shared constants for the paged two-wire register port
// Assumes: 50 MHz core clock
// Notes:   Offsets are byte register addresses on the serial bus
package pir_pkg;
  localparam logic [2:0] ADDR_TOP      = 3'b101;   // Fixed upper target address bits
  localparam logic [3:0] ADDR_LOW_GND  = 4'h0;     // Strap tied to ground
  localparam logic [3:0] ADDR_LOW_VCC  = 4'hF;     // Strap tied to supply
  localparam logic [3:0] ADDR_LOW_SCL  = 4'h5;     // Strap tied to clock line
  localparam logic [3:0] ADDR_LOW_SDA  = 4'hA;     // Strap tied to data line
  localparam logic [7:0] OFS_IRQ_MASK  = 8'hF0;    // Interrupt enable mask
  localparam logic [7:0] OFS_IRQ_STAT  = 8'hF1;    // Interrupt event status
  localparam logic [7:0] OFS_PAGE_SEL  = 8'hFD;    // Page select
  localparam logic [7:0] OFS_UNLOCK    = 8'hFE;    // Page select unlock
  localparam logic [7:0] UNLOCK_KEY    = 8'hC5;    // One-shot unlock key
  localparam logic [7:0] RST_MASK      = 8'h00;    // Mask reset value
  localparam logic [7:0] RST_STAT      = 8'h00;    // Status reset value
  localparam logic [7:0] RST_PAGE      = 8'h00;    // Page reset value
  localparam logic [7:0] RST_UNLOCK    = 8'h00;    // Unlock reset value
  localparam logic [7:0] PAGE_LED      = 8'h00;    // LED control page
  localparam logic [7:0] PAGE_FUNC     = 8'h03;    // Function page
  localparam logic [7:0] OPEN_FIRST    = 8'h18;    // Open detect window
  localparam logic [7:0] OPEN_LAST     = 8'h2D;
  localparam logic [7:0] SHORT_FIRST   = 8'h30;    // Short detect window
  localparam logic [7:0] SHORT_LAST    = 8'h45;
  localparam logic [7:0] FUNC_RD_OFS   = 8'h11;    // Readable function location
  localparam int         BIT_OPEN      = 0;        // Mask and status positions
  localparam int         BIT_SHORT     = 1;
  localparam int         BIT_BREATH    = 2;
  localparam int         BIT_AUTOCLR   = 3;
  localparam int         BIT_PROF1     = 2;
  localparam int         BIT_PROF2     = 3;
  localparam int         BIT_PROF3     = 4;
  localparam int         CLK_HZ        = 50_000_000;
  localparam int         AUTOCLR_MS    = 8;        // Auto clear low time
  localparam int         AUTOCLR_CYC   = AUTOCLR_MS * (CLK_HZ / 1000);
endpackage

/* File: src/pir_sync_if.sv */
// Purpose: Bundle of synchronised pin levels and detected bus events
// Assumes: Driven by the line sampler only
// Notes:   All signals on clk
`timescale 1ns/1ps
interface pir_sync_if;
  logic scl;      // Synchronised clock line
  logic sda;      // Synchronised data line
  logic rise;     // Clock line rising edge
  logic fall;     // Clock line falling edge
  logic start;    // Start or repeated start
  logic stop;     // Stop condition
  modport src (output scl, sda, rise, fall, start, stop);
  modport dst (input scl, sda, rise, fall, start, stop);
endinterface

/* File: src/pir_line_sampler.sv */
// Purpose: Two-stage synchronisers and bus event detection
// Assumes: Pins asynchronous to clk
// Notes:   First stages feed only the second stages
`timescale 1ns/1ps
module pir_line_sampler (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  pir_sync_if.src   ev
);
  logic [1:0] scl_m;   // Clock line sync stages
  logic [1:0] sda_m;   // Data line sync stages
  logic       scl_d;   // Previous clock level
  logic       sda_d;   // Previous data level

  // Synchronisers, idle high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_m <= 2'h3;
      sda_m <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= {scl_m[0], scl_in};
      sda_m <= {sda_m[0], sda_in};
      scl_d <= scl_m[1];
      sda_d <= sda_m[1];
    end
  end

  assign ev.scl   = scl_m[1];
  assign ev.sda   = sda_m[1];
  assign ev.rise  = scl_m[1] & ~scl_d;
  assign ev.fall  = ~scl_m[1] & scl_d;
  assign ev.start = scl_m[1] & scl_d & sda_d & ~sda_m[1];
  assign ev.stop  = scl_m[1] & scl_d & ~sda_d & sda_m[1];
endmodule

/* File: src/pir_port.sv */
// Purpose: Two-wire target port with paged register map and interrupt logic
// Assumes: Controller follows the bus protocol; page contents live outside
// Notes:   Page writes are forwarded on the page_* ports; paged reads take page_rdata
// Operation
// - First byte: seven address bits, direction bit
// - Address 101 plus strap-selected low nibble
// - Start is data fall with clock high
// - Stop is data rise with clock high
// - Acknowledge address byte only on match
// - Register address then data, all acknowledged
// - Pointer increments per data byte, acknowledged or not
// - Only listed registers readable, others zero
// - Write pointer, repeated start, then read
// - Page values zero to three select pages
// - Page select locked until unlocked
// - Key permits one page write, then relocks
// - Non-global writes go to selected page
// - Page select resets to LED page
// - Mask bits enable open, short, breath
// - Optional auto clear after 8 ms low
// - Status: open, short, three profile finishes
`timescale 1ns/1ps
module pir_port #(
  parameter int AUTOCLR_CYC = pir_pkg::AUTOCLR_CYC  // Auto clear low time
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl_in,          // Clock line pin
  input  wire logic       sda_in,          // Data line pin level
  output logic            sda_out,         // Data line drive value, always 0
  output logic            sda_oe,          // Data line pull-low enable
  input  wire logic [1:0] strap_sel,       // Strap: 0 gnd, 1 vcc, 2 clock, 3 data
  input  wire logic       open_seen,       // Open event pulse
  input  wire logic       short_seen,      // Short event pulse
  input  wire logic       profile1_finished, // Breathing profile finish pulses
  input  wire logic       profile2_finished,
  input  wire logic       profile3_finished,
  input  wire logic [7:0] page_rdata,      // Paged read data for the register at ptr
  output logic            page_we,         // Paged write strobe
  output logic [1:0]      page_num,        // Selected page for strobe
  output logic [7:0]      page_addr,       // Paged write address
  output logic [7:0]      page_wdata,      // Paged write data
  output logic            irq_low_output   // Active-low interrupt
);
  typedef enum logic [2:0] {
    PIR_IDLE, PIR_RX, PIR_ACK, PIR_TX, PIR_TACK
  } pir_state_t;

  pir_sync_if ev ();                  // Synchronised line events
  pir_state_t state;                  // Bus state
  logic [2:0] bitcnt;                 // Bit counter
  logic [7:0] shreg;                  // Shift register
  logic [1:0] byteno;                 // 0 addr, 1 pointer, 2 data
  logic       rd_mode;                // Current transfer reads
  logic [7:0] ptr;                    // Register pointer
  logic [7:0] mask;                   // interrupt_enable_mask
  logic [7:0] status;                 // interrupt_event_status
  logic [7:0] page_sel;               // page_select
  logic [7:0] page_unlock_key;        // page_select_unlock
  logic       acking;                 // Ack pending this byte
  logic [3:0] addr_low;               // Strapped low address bits
  logic [31:0] low_cnt;               // Interrupt low time
  logic       autoclr;                // Auto clear pulse
  logic [7:0] rd_val;                 // Read mux
  logic       wr_strobe;              // Data byte write
  logic [4:0] events;                 // Status set terms
  logic       irq_act;                // Any enabled status
  logic [1:0] strap_m0;               // Strap first sync stage
  logic [1:0] strap_m1;               // Strap second sync stage

  pir_line_sampler u_samp (
    .clk    (clk),
    .arst_n (arst_n),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .ev     (ev)
  );

  // Strap pins pass two stages before decode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_m0 <= 2'h0;
      strap_m1 <= 2'h0;
    end else begin
      strap_m0 <= strap_sel;
      strap_m1 <= strap_m0;
    end
  end

  // Strap decode
  always_comb begin
    unique case (strap_m1)
      2'h0: addr_low = pir_pkg::ADDR_LOW_GND;
      2'h1: addr_low = pir_pkg::ADDR_LOW_VCC;
      2'h2: addr_low = pir_pkg::ADDR_LOW_SCL;
      2'h3: addr_low = pir_pkg::ADDR_LOW_SDA;
    endcase
  end

  // Readable map only
  always_comb begin
    rd_val = 8'h00;
    if (ptr == pir_pkg::OFS_UNLOCK) rd_val = page_unlock_key;
    else if (ptr == pir_pkg::OFS_IRQ_STAT) rd_val = status;
    else if (page_sel == pir_pkg::PAGE_LED &&
             ((ptr >= pir_pkg::OPEN_FIRST && ptr <= pir_pkg::OPEN_LAST) ||
              (ptr >= pir_pkg::SHORT_FIRST && ptr <= pir_pkg::SHORT_LAST)))
      rd_val = page_rdata;
    else if (page_sel == pir_pkg::PAGE_FUNC && ptr == pir_pkg::FUNC_RD_OFS)
      rd_val = page_rdata;
  end

  // Data byte completes at eighth rising clock edge
  assign wr_strobe = (state == PIR_RX) && ev.rise && bitcnt == 3'h7 && byteno == 2'h2;

  // Bus state, bit and byte tracking
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= PIR_IDLE;
      bitcnt  <= 3'h0;
      shreg   <= 8'h00;
      byteno  <= 2'h0;
      rd_mode <= 1'b0;
      acking  <= 1'b0;
      ptr     <= 8'h00;
    end else if (ev.stop) begin
      state <= PIR_IDLE;
    end else if (ev.start) begin
      state  <= PIR_RX;
      bitcnt <= 3'h0;
      byteno <= 2'h0;
    end else begin
      unique case (state)
        PIR_IDLE: begin
        end
        PIR_RX: if (ev.rise) begin
          shreg  <= {shreg[6:0], ev.sda};
          bitcnt <= bitcnt + 3'h1;
          if (bitcnt == 3'h7) begin
            if (byteno == 2'h0) begin
              acking  <= ({shreg[6:0], ev.sda} >> 1) ==
                         {1'b0, pir_pkg::ADDR_TOP, addr_low};
              rd_mode <= ev.sda;
            end else begin
              acking <= 1'b1;
              if (byteno == 2'h1) ptr <= {shreg[6:0], ev.sda};
              else ptr <= ptr + 8'h01;
            end
            state <= PIR_ACK;
          end
        end
        PIR_ACK: if (ev.fall && bitcnt == 3'h0) begin
          bitcnt <= 3'h1;  // Ack clock now high phase pending
        end else if (ev.fall) begin
          bitcnt <= 3'h0;
          if (!acking) state <= PIR_IDLE;
          else if (byteno == 2'h0 && rd_mode) begin
            state <= PIR_TX;
            shreg <= rd_val;
          end else begin
            state <= PIR_RX;
            if (byteno != 2'h2) byteno <= byteno + 2'h1;
          end
        end
        PIR_TX: if (ev.fall) begin
          bitcnt <= bitcnt + 3'h1;
          shreg  <= {shreg[6:0], 1'b0};
          if (bitcnt == 3'h7) begin
            state <= PIR_TACK;
            ptr   <= ptr + 8'h01;
          end
        end
        PIR_TACK: if (ev.rise) begin
          acking <= ~ev.sda;  // Controller ack continues read
        end else if (ev.fall) begin
          if (acking) begin
            state <= PIR_TX;
            shreg <= rd_val;  // Pointer already moved on
          end else state <= PIR_IDLE;
        end
        default: state <= PIR_IDLE;
      endcase
    end
  end

  // Data line drive, registered; ack or read bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      // Ack only after the eighth clock has fallen, never while it is high
      sda_oe  <= (state == PIR_ACK && acking && bitcnt == 3'h1) ||
                 (state == PIR_TX && !shreg[7]);
    end
  end

  // Page select, unlock key and mask writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_sel        <= pir_pkg::RST_PAGE;
      page_unlock_key <= pir_pkg::RST_UNLOCK;
      mask            <= pir_pkg::RST_MASK;
    end else if (wr_strobe) begin
      unique case ({shreg[6:0], ev.sda} == 8'h00 ? ptr : ptr)
        pir_pkg::OFS_PAGE_SEL: if (page_unlock_key == pir_pkg::UNLOCK_KEY) begin
          page_sel        <= {shreg[6:0], ev.sda};
          page_unlock_key <= pir_pkg::RST_UNLOCK;
        end
        pir_pkg::OFS_UNLOCK: page_unlock_key <= {shreg[6:0], ev.sda};
        pir_pkg::OFS_IRQ_MASK: mask <= {shreg[6:0], ev.sda};
        default: begin
        end
      endcase
    end
  end

  // Forward paged writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_we    <= 1'b0;
      page_num   <= 2'h0;
      page_addr  <= 8'h00;
      page_wdata <= 8'h00;
    end else begin
      page_we <= wr_strobe && ptr < pir_pkg::OFS_IRQ_MASK &&
                 page_sel <= pir_pkg::PAGE_FUNC;
      if (wr_strobe) begin
        page_num   <= page_sel[1:0];
        page_addr  <= ptr;
        page_wdata <= {shreg[6:0], ev.sda};
      end
    end
  end

  // Status set terms
  always_comb begin
    events = 5'h00;
    events[pir_pkg::BIT_OPEN]  = open_seen;
    events[pir_pkg::BIT_SHORT] = short_seen;
    events[pir_pkg::BIT_PROF1] = profile1_finished;
    events[pir_pkg::BIT_PROF2] = profile2_finished;
    events[pir_pkg::BIT_PROF3] = profile3_finished;
  end

  // Sticky status, cleared by auto clear; set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) status <= pir_pkg::RST_STAT;
    else status <= {3'h0, (autoclr ? 5'h00 : status[4:0]) | events};
  end

  assign irq_act = (status[pir_pkg::BIT_OPEN] & mask[pir_pkg::BIT_OPEN]) |
                   (status[pir_pkg::BIT_SHORT] & mask[pir_pkg::BIT_SHORT]) |
                   (|status[4:2] & mask[pir_pkg::BIT_BREATH]);

  // Interrupt output and low time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_low_output <= 1'b1;
      low_cnt        <= 32'h0;
      autoclr        <= 1'b0;
    end else begin
      irq_low_output <= ~(irq_act & ~autoclr);
      autoclr <= 1'b0;
      if (irq_low_output || !mask[pir_pkg::BIT_AUTOCLR]) low_cnt <= 32'h0;
      else if (low_cnt >= 32'(AUTOCLR_CYC)) begin
        autoclr <= 1'b1;
        low_cnt <= 32'h0;
      end else low_cnt <= low_cnt + 32'h1;
    end
  end

  a_unlock_once: assert property (@(posedge clk) disable iff (!arst_n)
    wr_strobe && ptr == pir_pkg::OFS_PAGE_SEL &&
    page_unlock_key == pir_pkg::UNLOCK_KEY |=> page_unlock_key == 8'h00)
    else $error("unlock key not cleared");
  a_locked_page: assert property (@(posedge clk) disable iff (!arst_n)
    page_unlock_key != pir_pkg::UNLOCK_KEY |=> $stable(page_sel))
    else $error("locked page select changed");
  a_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
    irq_act && !autoclr |=> !irq_low_output)
    else $error("interrupt not asserted");
  a_no_autoclr: assert property (@(posedge clk) disable iff (!arst_n)
    !mask[pir_pkg::BIT_AUTOCLR] |=> !autoclr)
    else $error("auto clear while disabled");
  a_nak_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    state == PIR_ACK && !acking |-> !sda_oe)
    else $error("ack driven on mismatch");
  a_ptr_incr: assert property (@(posedge clk) disable iff (!arst_n)
    wr_strobe |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not increment");
  a_stop_idle: assert property (@(posedge clk) disable iff (!arst_n)
    ev.stop |=> state == PIR_IDLE)
    else $error("stop not honoured");
  // Ack slot: address matched or byte taken, ninth clock low and high phases
  sequence s_ack_slot;
    state == PIR_ACK && acking && bitcnt == 3'h1;
  endsequence
  a_ack_drive: assert property (@(posedge clk) disable iff (!arst_n)
    s_ack_slot |=> sda_oe)
    else $error("ack not driven");
  a_drive_low_phase: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(sda_oe) |-> !ev.scl)
    else $error("data line driven while clock high");
  a_event_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    open_seen |=> status[pir_pkg::BIT_OPEN])
    else $error("open event lost");
endmodule

/* File: tb/pir_ctrl_model.sv */
// Purpose: Behavioural two-wire bus controller that drives the port
// Assumes: Open-drain data line with pull-up; clock line idles high
// Notes:   Low phase 100 ns, high phase 60 ns, clock still between frames
`timescale 1ns/1ps
module pir_ctrl_model (
  output logic      scl,     // Clock line
  output logic      sda_low, // High while pulling data low
  input  wire logic sda      // Resolved data line
);
  // Idle: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start: data falls while clock high
  task automatic start();
    #50 sda_low = 1'b0;
    #50 scl = 1'b1;
    #60 sda_low = 1'b1;
    #60 scl = 1'b0;
  endtask
  // Stop: data rises while clock high, then idle
  task automatic stop();
    #50 sda_low = 1'b1;
    #50 scl = 1'b1;
    #60 sda_low = 1'b0;
    #60;
  endtask
  // One pulse: data set late in low phase, sampled late in high phase
  task automatic bit_io(input logic b, output logic s);
    #90 sda_low = ~b;
    #10 scl = 1'b1;
    #55 s = sda;
    #5 scl = 1'b0;
  endtask
  // Byte out MSB first, then release for the acknowledge pulse
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // Byte in MSB first, then acknowledge to continue or not to end
  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule

/* File: tb/test_pir_port.sv */
// Purpose: Self-checking bench for the paged two-wire register port
// Assumes: Partner model as bus controller; short auto clear time
// Notes:   Paged read data is a fixed pattern
`timescale 1ns/1ps
module test_pir_port;
  localparam int         ACYC = 50;                                  // Short auto clear
  localparam logic [6:0] DEV  = {pir_pkg::ADDR_TOP, pir_pkg::ADDR_LOW_GND}; // Own address
  typedef struct packed {
    logic [1:0] strap;
    logic [6:0] addr;
    logic       ack;
  } pir_row_t;
  logic       clk, arst_n, scl, sda_low, sda_out, sda_oe, page_we, irq_low_output, a;
  logic [1:0] strap_sel, page_num;
  logic [4:0] ev;                                     // Event pulses to the port
  logic [7:0] page_rdata, page_addr, page_wdata, q;
  int         n_errors, n_tests, n_we, w;
  wire        sda = ~(sda_low | (sda_oe & ~sda_out)); // Wired-AND with pull-up
  // Address rows: strap, address, expected acknowledge
  pir_row_t rows [8] = '{
    '{2'd0, {3'b101, 4'h0}, 1'b1}, '{2'd1, {3'b101, 4'hF}, 1'b1},
    '{2'd2, {3'b101, 4'h5}, 1'b1}, '{2'd3, {3'b101, 4'hA}, 1'b1},
    '{2'd0, {3'b101, 4'hF}, 1'b0}, '{2'd2, {3'b101, 4'hA}, 1'b0},
    '{2'd3, {3'b101, 4'h5}, 1'b0}, '{2'd0, {3'b001, 4'h0}, 1'b0}};

  pir_port #(.AUTOCLR_CYC(ACYC)) pir_port_i (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap_sel(strap_sel), .open_seen(ev[0]), .short_seen(ev[1]),
    .profile1_finished(ev[2]), .profile2_finished(ev[3]), .profile3_finished(ev[4]),
    .page_rdata(page_rdata), .page_we(page_we), .page_num(page_num),
    .page_addr(page_addr), .page_wdata(page_wdata), .irq_low_output(irq_low_output));
  pir_ctrl_model pir_ctrl_model_i (.scl(scl), .sda_low(sda_low), .sda(sda));

  // Core clock
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // Count paged write strobes
  always @(posedge clk) begin
    if (page_we === 1'b1) n_we <= n_we + 1;
  end

  // Compare one byte result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Send a byte that must be acknowledged
  task automatic sendc(input logic [7:0] d);
    pir_ctrl_model_i.send(d, a);
    chk({7'h0, a}, 8'h01, "byte ack");
  endtask
  // Write n consecutive bytes starting at d
  task automatic wr(input logic [7:0] r, input logic [7:0] d, input int n);
    pir_ctrl_model_i.start();
    sendc({DEV, 1'b0});
    sendc(r);
    for (int i = 0; i < n; i++) sendc(d + 8'(i));
    pir_ctrl_model_i.stop();
  endtask
  // Pointer write, repeated start, read n bytes
  task automatic rd(input logic [7:0] r, input logic [7:0] e0, input logic [7:0] e1,
                    input int n);
    pir_ctrl_model_i.start();
    sendc({DEV, 1'b0});
    sendc(r);
    pir_ctrl_model_i.start();
    sendc({DEV, 1'b1});
    for (int i = 0; i < n; i++) begin
      pir_ctrl_model_i.recv(i < n - 1, q);
      chk(q, (i == 0) ? e0 : e1, "read data");
    end
    pir_ctrl_model_i.stop();
  endtask
  // One-cycle event pulse, then let it land
  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 5'h00;
    repeat (6) @(posedge clk);
  endtask
  // Interrupt level after a wait
  task automatic irq_is(input logic e, input int cyc);
    repeat (cyc) @(posedge clk);
    #1;
    chk({7'h0, irq_low_output}, {7'h0, e}, "interrupt level");
  endtask
  // Counts and verdict
  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog against a hung bus
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    strap_sel = 2'd0;
    ev = 5'h00;
    page_rdata = 8'h5A;
    n_errors = 0;
    n_tests = 0;
    n_we = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    irq_is(1'b1, 4);
    rd(8'hF1, 8'h00, 8'h00, 1);
    rd(8'hFE, 8'h00, 8'h00, 1);
    $display("test reset done");
    // Address table
    foreach (rows[i]) begin
      strap_sel <= rows[i].strap;
      @(posedge clk);
      pir_ctrl_model_i.start();
      pir_ctrl_model_i.send({rows[i].addr, 1'b0}, a);
      pir_ctrl_model_i.stop();
      chk({7'h0, a}, {7'h0, rows[i].ack}, "address ack");
    end
    strap_sel <= 2'd0;
    $display("test address done");
    // Locked page select, then one-shot key for every page
    wr(8'hFD, 8'h03, 1);
    wr(8'h10, 8'h77, 1);
    chk({6'h0, page_num}, 8'h00, "locked page");
    chk(page_addr, 8'h10, "paged address");
    chk(page_wdata, 8'h77, "paged data");
    for (int p = 0; p < 4; p++) begin
      wr(8'hFE, pir_pkg::UNLOCK_KEY, 1);
      rd(8'hFE, 8'hC5, 8'h00, 1);
      wr(8'hFD, 8'(p), 1);
      rd(8'hFE, 8'h00, 8'h00, 1);
      wr(8'h20, 8'h40, 1);
      chk({6'h0, page_num}, 8'(p), "selected page");
    end
    wr(8'hFD, 8'h01, 1);
    w = n_we;
    wr(8'h10, 8'h20, 3);
    chk(8'(n_we - w), 8'h03, "strobe count");
    chk({6'h0, page_num}, 8'h03, "page kept");
    chk(page_addr, 8'h12, "last address");
    chk(page_wdata, 8'h22, "last data");
    $display("test paging done");
    // Readable locations only
    rd(8'h11, 8'h5A, 8'h00, 1);
    rd(8'h18, 8'h00, 8'h00, 1);
    rd(8'hF0, 8'h00, 8'h00, 1);
    wr(8'hFE, pir_pkg::UNLOCK_KEY, 1);
    wr(8'hFD, pir_pkg::PAGE_LED, 1);
    rd(8'h18, 8'h5A, 8'h00, 1);
    rd(8'h2D, 8'h5A, 8'h00, 2);
    rd(8'h45, 8'h5A, 8'h00, 2);
    $display("test reads done");
    // Interrupt mask, status and auto clear
    wr(8'hF0, 8'h01, 1);
    pulse(5'b00010);
    irq_is(1'b1, 1);
    rd(8'hF1, 8'h02, 8'h00, 1);
    pulse(5'b00001);
    irq_is(1'b0, 1);
    pulse(5'b11100);
    rd(8'hF1, 8'h1F, 8'h00, 1);
    irq_is(1'b0, 2 * ACYC);
    wr(8'hF0, 8'h09, 1);
    irq_is(1'b1, ACYC + 20);
    rd(8'hF1, 8'h00, 8'h00, 1);
    wr(8'hF0, 8'h04, 1);
    pulse(5'b01000);
    irq_is(1'b0, 1);
    $display("test interrupt done");
    // Reset in mid-run, with page 3 selected before it
    wr(8'hFE, pir_pkg::UNLOCK_KEY, 1);
    wr(8'hFD, pir_pkg::PAGE_FUNC, 1);
    wr(8'hFE, pir_pkg::UNLOCK_KEY, 1);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    irq_is(1'b1, 4);
    rd(8'hFE, 8'h00, 8'h00, 1);
    wr(8'h10, 8'h33, 1);
    chk({6'h0, page_num}, 8'h00, "page after reset");
    $display("test rereset done");
    complete_run();
  end
endmodule
